// ===== hdl/bcr_pkg.sv
// Package of offsets, field positions and reset values for the regulator control registers
package bcr_pkg;
  // Register offsets on the serial register port
  localparam logic [7:0] OFS_REG3_DECAY_CTRL = 8'h22;
  localparam logic [7:0] OFS_REG3_NORMAL_VOLTAGE = 8'h23;
  localparam logic [7:0] OFS_REG3_SLEEP_VOLTAGE_CTRL = 8'h24;
  localparam logic [7:0] OFS_REG4_CONTROL = 8'h25;
  localparam logic [7:0] OFS_REG5_CONTROL = 8'h26;
  // Field positions
  localparam int POS_DECAY_SELECT = 0;
  localparam int POS_CODE_LSB = 1;
  localparam int POS_CODE_MSB = 7;
  localparam int POS_REG3_SLEEP_ENABLE = 0;
  localparam int POS_ON_BIT = 0;
  localparam int POS_MODE_SELECT = 1;
  localparam int POS_KEEP_LSB = 2;
  localparam int POS_KEEP_MSB = 3;
  localparam int POS_SLEEP_EN_LSB = 4;
  localparam int POS_SLEEP_EN_MSB = 5;
  // Two-bit sleep enable codes
  localparam logic [1:0] SLEEP_EN_OFF = 2'h0;
  localparam logic [1:0] SLEEP_EN_ON = 2'h3;
  // Reset values
  localparam logic [7:0] RST_REG3_DECAY_CTRL = 8'h00;
  localparam logic [6:0] RST_REG3_NORMAL_CODE = 7'h00;
  localparam logic [7:0] RST_REG3_SLEEP_VOLTAGE_CTRL = 8'h00;
  localparam logic [5:0] RST_REG45_CONTROL = 6'h0c;
  // Which sleep pin a regulator follows, fixed at manufacture
  typedef enum {BCR_PIN_THREE, BCR_PIN_SIX} bcr_sleep_pin_t;
endpackage : bcr_pkg

// ===== hdl/bcr_sleep_if.sv
// Interface between the register bank and one sleep selector
`timescale 1ns/100ps
interface bcr_sleep_if;
  logic enable;
  logic use_sleep;
  modport bank (output enable, input use_sleep);
  modport sel (input enable, output use_sleep);
endinterface : bcr_sleep_if

// ===== hdl/bcr_sleep_sel.sv
// Sleep selector: registers a sleep-or-normal flag for one regulator from its enable and strapped pin
`timescale 1ns/100ps
module bcr_sleep_sel #(
  parameter bcr_pkg::bcr_sleep_pin_t P_PIN = bcr_pkg::BCR_PIN_THREE
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_control_pin_three_sleep_one,
  input wire logic i_control_pin_six_sleep_two,
  bcr_sleep_if.sel bus
);
  logic use_sleep;
  logic next_use_sleep;
  logic pin_level;

  // Strap decides the pin; low pin with enable set means sleep
  always_comb
  begin
    pin_level = (P_PIN == bcr_pkg::BCR_PIN_SIX) ? i_control_pin_six_sleep_two : i_control_pin_three_sleep_one;
    next_use_sleep = bus.enable && !pin_level;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      use_sleep <= 1'b0;
    else
      use_sleep <= next_use_sleep;
  end

  assign bus.use_sleep = use_sleep;

  sleep_follow_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !bus.enable |=> !use_sleep) else $error("sleep taken while disabled");
endmodule : bcr_sleep_sel

// ===== hdl/bcr_regs.sv
// Control register bank for the third, fourth and fifth step-down regulators
`timescale 1ns/100ps
// Notes on behaviour
// - Bit 0 of the decay register picks slewing down (0) or free decay (1) for the third regulator.
// - Bits 7:1 of the decay register are spare storage that reads back what was written.
// - Bits 7:1 of the normal voltage register hold the third regulator's normal code; bit 0 reads zero.
// - Bits 7:1 of the sleep control register hold the sleep code, used only while its enable is 1.
// - With enable 0 the normal code applies; with 1 the sleep code applies while the assigned pin is low.
// - Each regulator follows either control pin three or control pin six, fixed at manufacture.
// - For the fourth and fifth regulators, enable code 11 sleeps on a low pin and 00 never sleeps.
// - Bit 1 of the fourth and fifth control registers selects forced pulse-width operation when 1.
// - Bit 0 of the fourth and fifth control registers at 0 turns the regulator off whatever the pins say.
module bcr_regs #(
  parameter bcr_pkg::bcr_sleep_pin_t P_REG3_PIN = bcr_pkg::BCR_PIN_THREE,
  parameter bcr_pkg::bcr_sleep_pin_t P_REG4_PIN = bcr_pkg::BCR_PIN_THREE,
  parameter bcr_pkg::bcr_sleep_pin_t P_REG5_PIN = bcr_pkg::BCR_PIN_SIX
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_control_pin_three_sleep_one,
  input wire logic i_control_pin_six_sleep_two,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_reg3_decay_select,
  output logic [6:0] o_reg3_target_code,
  output logic o_reg3_sleep_active,
  output logic o_reg4_sleep_active,
  output logic o_reg4_mode_select,
  output logic o_reg4_on,
  output logic o_reg5_sleep_active,
  output logic o_reg5_mode_select,
  output logic o_reg5_on
);
  // Stored register contents
  logic [7:0] decay_ctrl;
  logic [6:0] normal_code;
  logic [7:0] sleep_ctrl;
  logic [5:0] ctrl4;
  logic [5:0] ctrl5;
  logic [7:0] next_decay_ctrl;
  logic [6:0] next_normal_code;
  logic [7:0] next_sleep_ctrl;
  logic [5:0] next_ctrl4;
  logic [5:0] next_ctrl5;
  // Read port and regulator outputs
  logic [7:0] next_rd_data;
  logic next_rd_valid;
  logic [6:0] next_target_code;
  logic [7:0] rd_mux;

  bcr_sleep_if sel3 ();
  bcr_sleep_if sel4 ();
  bcr_sleep_if sel5 ();

  // Writes land on the addressed register only; unmapped offsets are ignored
  always_comb
  begin
    next_decay_ctrl = decay_ctrl;
    next_normal_code = normal_code;
    next_sleep_ctrl = sleep_ctrl;
    next_ctrl4 = ctrl4;
    next_ctrl5 = ctrl5;
    if (i_wr_en)
    begin
      if (i_addr == bcr_pkg::OFS_REG3_DECAY_CTRL)
        next_decay_ctrl = i_wr_data;
      else if (i_addr == bcr_pkg::OFS_REG3_NORMAL_VOLTAGE)
        next_normal_code = i_wr_data[bcr_pkg::POS_CODE_MSB:bcr_pkg::POS_CODE_LSB];
      else if (i_addr == bcr_pkg::OFS_REG3_SLEEP_VOLTAGE_CTRL)
        next_sleep_ctrl = i_wr_data;
      else if (i_addr == bcr_pkg::OFS_REG4_CONTROL)
        next_ctrl4 = i_wr_data[5:0];
      else if (i_addr == bcr_pkg::OFS_REG5_CONTROL)
        next_ctrl5 = i_wr_data[5:0];
    end
  end

  // Reserved bits are not stored, so they read zero
  always_comb
  begin
    if (i_addr == bcr_pkg::OFS_REG3_DECAY_CTRL)
      rd_mux = decay_ctrl;
    else if (i_addr == bcr_pkg::OFS_REG3_NORMAL_VOLTAGE)
      rd_mux = {normal_code, 1'b0};
    else if (i_addr == bcr_pkg::OFS_REG3_SLEEP_VOLTAGE_CTRL)
      rd_mux = sleep_ctrl;
    else if (i_addr == bcr_pkg::OFS_REG4_CONTROL)
      rd_mux = {2'h0, ctrl4};
    else if (i_addr == bcr_pkg::OFS_REG5_CONTROL)
      rd_mux = {2'h0, ctrl5};
    else
      rd_mux = 8'h00;
    next_rd_valid = i_rd_en;
    next_rd_data = i_rd_en ? rd_mux : o_rd_data;
  end

  // Sleep enables handed to the selectors; reserved codes 01 and 10 never sleep
  assign sel3.enable = sleep_ctrl[bcr_pkg::POS_REG3_SLEEP_ENABLE];
  assign sel4.enable = ctrl4[bcr_pkg::POS_SLEEP_EN_MSB:bcr_pkg::POS_SLEEP_EN_LSB] == bcr_pkg::SLEEP_EN_ON;
  assign sel5.enable = ctrl5[bcr_pkg::POS_SLEEP_EN_MSB:bcr_pkg::POS_SLEEP_EN_LSB] == bcr_pkg::SLEEP_EN_ON;

  // Target code follows the selector, one cycle behind it
  always_comb
  begin
    next_target_code = sel3.use_sleep ? sleep_ctrl[bcr_pkg::POS_CODE_MSB:bcr_pkg::POS_CODE_LSB] : normal_code;
  end

  // Registers only; all outputs come from here
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      decay_ctrl <= bcr_pkg::RST_REG3_DECAY_CTRL;
      normal_code <= bcr_pkg::RST_REG3_NORMAL_CODE;
      sleep_ctrl <= bcr_pkg::RST_REG3_SLEEP_VOLTAGE_CTRL;
      ctrl4 <= bcr_pkg::RST_REG45_CONTROL;
      ctrl5 <= bcr_pkg::RST_REG45_CONTROL;
      o_rd_data <= 8'h00;
      o_rd_valid <= 1'b0;
      o_reg3_decay_select <= 1'b0;
      o_reg3_target_code <= bcr_pkg::RST_REG3_NORMAL_CODE;
      o_reg3_sleep_active <= 1'b0;
      o_reg4_sleep_active <= 1'b0;
      o_reg4_mode_select <= 1'b0;
      o_reg4_on <= 1'b0;
      o_reg5_sleep_active <= 1'b0;
      o_reg5_mode_select <= 1'b0;
      o_reg5_on <= 1'b0;
    end
    else
    begin
      decay_ctrl <= next_decay_ctrl;
      normal_code <= next_normal_code;
      sleep_ctrl <= next_sleep_ctrl;
      ctrl4 <= next_ctrl4;
      ctrl5 <= next_ctrl5;
      o_rd_data <= next_rd_data;
      o_rd_valid <= next_rd_valid;
      o_reg3_decay_select <= decay_ctrl[bcr_pkg::POS_DECAY_SELECT];
      o_reg3_target_code <= next_target_code;
      o_reg3_sleep_active <= sel3.use_sleep;
      o_reg4_sleep_active <= sel4.use_sleep;
      o_reg4_mode_select <= ctrl4[bcr_pkg::POS_MODE_SELECT];
      o_reg4_on <= ctrl4[bcr_pkg::POS_ON_BIT];
      o_reg5_sleep_active <= sel5.use_sleep;
      o_reg5_mode_select <= ctrl5[bcr_pkg::POS_MODE_SELECT];
      o_reg5_on <= ctrl5[bcr_pkg::POS_ON_BIT];
    end
  end

  // One selector per regulator; the strap parameter names its pin
  bcr_sleep_sel #(.P_PIN(P_REG3_PIN)) u_sel3 (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_control_pin_three_sleep_one(i_control_pin_three_sleep_one),
    .i_control_pin_six_sleep_two(i_control_pin_six_sleep_two),
    .bus(sel3.sel)
  );
  bcr_sleep_sel #(.P_PIN(P_REG4_PIN)) u_sel4 (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_control_pin_three_sleep_one(i_control_pin_three_sleep_one),
    .i_control_pin_six_sleep_two(i_control_pin_six_sleep_two),
    .bus(sel4.sel)
  );
  bcr_sleep_sel #(.P_PIN(P_REG5_PIN)) u_sel5 (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_control_pin_three_sleep_one(i_control_pin_three_sleep_one),
    .i_control_pin_six_sleep_two(i_control_pin_six_sleep_two),
    .bus(sel5.sel)
  );

  // Checks on register behaviour and outputs
  decay_out_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_wr_en && i_addr == bcr_pkg::OFS_REG3_DECAY_CTRL |=> ##1 o_reg3_decay_select == $past(i_wr_data[0], 2))
    else $error("decay select does not follow write");
  spare_back_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_wr_en && i_addr == bcr_pkg::OFS_REG3_DECAY_CTRL ##1 i_rd_en && i_addr == bcr_pkg::OFS_REG3_DECAY_CTRL
    |=> o_rd_data == $past(i_wr_data, 2))
    else $error("decay register readback wrong");
  code_lsb_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_rd_en && i_addr == bcr_pkg::OFS_REG3_NORMAL_VOLTAGE |=> o_rd_valid && !o_rd_data[0])
    else $error("reserved bit 0 not zero");
  normal_target_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !sleep_ctrl[0] [*3] |-> o_reg3_target_code == $past(normal_code))
    else $error("normal code not applied");
  // Target and sleep flag both come from the selector flop, so the code lags the register by one edge only
  sleep_target_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_reg3_sleep_active |-> o_reg3_target_code == $past(sleep_ctrl[bcr_pkg::POS_CODE_MSB:bcr_pkg::POS_CODE_LSB]))
    else $error("sleep code not applied");
  reg4_sleep_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    ctrl4[5:4] != bcr_pkg::SLEEP_EN_ON |=> ##1 !o_reg4_sleep_active)
    else $error("fourth regulator sleeps while not enabled");
  reg_off_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_wr_en && i_addr == bcr_pkg::OFS_REG5_CONTROL && !i_wr_data[0] |=> ##1 !o_reg5_on)
    else $error("fifth regulator not turned off");
  mode_out_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_wr_en && i_addr == bcr_pkg::OFS_REG4_CONTROL |=> ##1 o_reg4_mode_select == $past(i_wr_data[1], 2))
    else $error("mode select does not follow write");
  ctrl_upper_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_rd_en && (i_addr == bcr_pkg::OFS_REG4_CONTROL || i_addr == bcr_pkg::OFS_REG5_CONTROL)
    |=> o_rd_data[7:6] == 2'h0)
    else $error("read-only bits not zero");
  keep_reset_a: assert property (@(posedge i_ref_clk)
    $fell(i_srst) |-> ctrl4[3:2] == 2'h3 && ctrl5[3:2] == 2'h3)
    else $error("kept bits not reset to 11");
  reg5_sleep_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    ctrl5[5:4] != bcr_pkg::SLEEP_EN_ON |=> ##1 !o_reg5_sleep_active)
    else $error("fifth regulator sleeps while not enabled");
  reg4_off_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_wr_en && i_addr == bcr_pkg::OFS_REG4_CONTROL && !i_wr_data[0] |=> ##1 !o_reg4_on)
    else $error("fourth regulator not turned off");
  sleep3_cov: cover property (@(posedge i_ref_clk) disable iff (i_srst) $rose(o_reg3_sleep_active));
  sleep4_cov: cover property (@(posedge i_ref_clk) disable iff (i_srst) $rose(o_reg4_sleep_active));
  off5_cov: cover property (@(posedge i_ref_clk) disable iff (i_srst) $fell(o_reg5_on));
  read_cov: cover property (@(posedge i_ref_clk) disable iff (i_srst) o_rd_valid && o_rd_data != 8'h00);
endmodule : bcr_regs

// ===== tb/buck_regulator_ctrl_regs_tb.sv
// Self-checking testbench for the regulator control register bank
`timescale 1ns/100ps
module buck_regulator_ctrl_regs_tb;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wr_data = 8'h00;
  logic i_control_pin_three_sleep_one = 1'b1;
  logic i_control_pin_six_sleep_two = 1'b1;
  logic [7:0] o_rd_data;
  logic o_rd_valid;
  logic o_reg3_decay_select;
  logic [6:0] o_reg3_target_code;
  logic o_reg3_sleep_active;
  logic o_reg4_sleep_active;
  logic o_reg4_mode_select;
  logic o_reg4_on;
  logic o_reg5_sleep_active;
  logic o_reg5_mode_select;
  logic o_reg5_on;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;

  // 25 MHz clock
  always #20 i_ref_clk = ~i_ref_clk;

  // Regulators three and four follow pin three, regulator five pin six
  bcr_regs #(.P_REG3_PIN(bcr_pkg::BCR_PIN_THREE), .P_REG4_PIN(bcr_pkg::BCR_PIN_THREE),
    .P_REG5_PIN(bcr_pkg::BCR_PIN_SIX)) uut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_control_pin_three_sleep_one(i_control_pin_three_sleep_one),
    .i_control_pin_six_sleep_two(i_control_pin_six_sleep_two), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .o_reg3_decay_select(o_reg3_decay_select),
    .o_reg3_target_code(o_reg3_target_code), .o_reg3_sleep_active(o_reg3_sleep_active),
    .o_reg4_sleep_active(o_reg4_sleep_active), .o_reg4_mode_select(o_reg4_mode_select),
    .o_reg4_on(o_reg4_on), .o_reg5_sleep_active(o_reg5_sleep_active),
    .o_reg5_mode_select(o_reg5_mode_select), .o_reg5_on(o_reg5_on));

  task automatic test_done();
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1

  // Strobes rise and fall on falling edges so the rising edge sees them settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    i_wr_en = 1'b1;
    i_addr = a;
    i_wr_data = d;
    @(negedge i_ref_clk);
    i_wr_en = 1'b0;
  endtask : wr

  // Read valid stands one cycle, so the answer is sampled in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_ref_clk);
    i_rd_en = 1'b1;
    i_addr = a;
    @(negedge i_ref_clk);
    i_rd_en = 1'b0;
    chk1(o_rd_valid, 1'b1);
    chk8(o_rd_data, exp);
  endtask : rd

  // Outputs lag their cause by two edges, three for a sleep enable write; three cycles leave margin
  task automatic settle();
    repeat (3) @(negedge i_ref_clk);
  endtask : settle

  task automatic t_reset();
    chk1(o_rd_valid, 1'b0);
    chk1(o_reg4_on, 1'b0);
    rd(8'h22, 8'h00);
    rd(8'h23, 8'h00);
    rd(8'h24, 8'h00);
    rd(8'h25, 8'h0c);
    rd(8'h26, 8'h0c);
  endtask : t_reset

  task automatic t_regs();
    wr(8'h22, 8'hff);
    rd(8'h22, 8'hff);
    settle();
    chk1(o_reg3_decay_select, 1'b1);
    wr(8'h22, 8'hae);
    rd(8'h22, 8'hae);
    settle();
    chk1(o_reg3_decay_select, 1'b0);
    wr(8'h23, 8'hff);
    rd(8'h23, 8'hfe);
    wr(8'h26, 8'hff);
    rd(8'h26, 8'h3f);
    wr(8'h27, 8'h5a);
    rd(8'h27, 8'h00);
    rd(8'h21, 8'h00);
  endtask : t_regs

  task automatic t_reg3_sleep();
    wr(8'h23, 8'h54);
    wr(8'h24, 8'h2b);
    settle();
    chk8({1'b0, o_reg3_target_code}, 8'h2a);
    chk1(o_reg3_sleep_active, 1'b0);
    i_control_pin_six_sleep_two = 1'b0;
    settle();
    chk1(o_reg3_sleep_active, 1'b0);
    i_control_pin_three_sleep_one = 1'b0;
    settle();
    chk8({1'b0, o_reg3_target_code}, 8'h15);
    chk1(o_reg3_sleep_active, 1'b1);
    wr(8'h24, 8'h61);
    settle();
    chk8({1'b0, o_reg3_target_code}, 8'h30);
    wr(8'h24, 8'h2a);
    settle();
    chk8({1'b0, o_reg3_target_code}, 8'h2a);
    chk1(o_reg3_sleep_active, 1'b0);
    i_control_pin_three_sleep_one = 1'b1;
    i_control_pin_six_sleep_two = 1'b1;
  endtask : t_reg3_sleep

  task automatic t_reg45();
    wr(8'h25, 8'h3f);
    wr(8'h26, 8'h3c);
    settle();
    chk1(o_reg4_on, 1'b1);
    chk1(o_reg4_mode_select, 1'b1);
    chk1(o_reg5_on, 1'b0);
    chk1(o_reg5_mode_select, 1'b0);
    i_control_pin_three_sleep_one = 1'b0;
    settle();
    chk1(o_reg4_sleep_active, 1'b1);
    chk1(o_reg5_sleep_active, 1'b0);
    i_control_pin_six_sleep_two = 1'b0;
    settle();
    chk1(o_reg5_sleep_active, 1'b1);
    wr(8'h25, 8'h0d);
    wr(8'h26, 8'h0f);
    settle();
    chk1(o_reg4_sleep_active, 1'b0);
    chk1(o_reg5_sleep_active, 1'b0);
    chk1(o_reg4_on, 1'b1);
    chk1(o_reg5_on, 1'b1);
    chk1(o_reg5_mode_select, 1'b1);
    wr(8'h25, 8'h0c);
    settle();
    chk1(o_reg4_on, 1'b0);
    chk1(o_reg4_mode_select, 1'b0);
  endtask : t_reg45

  // Write then read in the next cycle, then a read and a write in one cycle; the read sees the old byte
  task automatic t_back_to_back();
    @(negedge i_ref_clk);
    i_wr_en = 1'b1;
    i_addr = 8'h22;
    i_wr_data = 8'h5b;
    @(negedge i_ref_clk);
    i_wr_en = 1'b0;
    i_rd_en = 1'b1;
    @(negedge i_ref_clk);
    chk1(o_rd_valid, 1'b1);
    chk8(o_rd_data, 8'h5b);
    i_wr_en = 1'b1;
    i_wr_data = 8'h34;
    @(negedge i_ref_clk);
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    chk8(o_rd_data, 8'h5b);
    rd(8'h22, 8'h34);
  endtask : t_back_to_back

  // Reset in mid-run must bring the fourth control register back to its default
  task automatic t_mid_reset();
    wr(8'h25, 8'h3f);
    @(negedge i_ref_clk);
    i_srst = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    i_srst = 1'b0;
    chk1(o_reg4_on, 1'b0);
    rd(8'h25, 8'h0c);
  endtask : t_mid_reset

  // Whole run needs about 120 cycles; the ceiling only catches a hang
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      test_done();
    end
  end

  // Main sequence
  initial
  begin
    repeat (20) @(negedge i_ref_clk);
    i_srst = 1'b0;
    settle();
    t_reset();
    t_regs();
    t_reg3_sleep();
    t_reg45();
    t_back_to_back();
    t_mid_reset();
    test_done();
  end
endmodule : buck_regulator_ctrl_regs_tb
